/* File: capcmp_pkg.sv */
// package: register map, field positions, reset values and timing counts
// for the capture/compare timer; assumes 32-bit axi4-lite, byte regs
package capcmp_pkg;

    // ****************************************************************
    // register indices (byte address is four times the index)
    // ****************************************************************
    localparam logic [7:0] idx_pin_select = 8'h0a;
    localparam logic [7:0] idx_control = 8'h12;
    localparam logic [7:0] idx_status = 8'h13;
    localparam logic [7:0] idx_capture_hi = 8'h14;
    localparam logic [7:0] idx_capture_lo = 8'h15;
    localparam logic [7:0] idx_compare_hi = 8'h16;
    localparam logic [7:0] idx_compare_lo = 8'h17;
    localparam logic [7:0] idx_count_hi = 8'h18;
    localparam logic [7:0] idx_count_lo = 8'h19;
    localparam logic [7:0] idx_alt_count_hi = 8'h1a;
    localparam logic [7:0] idx_alt_count_lo = 8'h1b;
    localparam logic [7:0] idx_irq_status = 8'h20;
    localparam logic [7:0] idx_irq_mask = 8'h21;
    localparam int addr_width = 8;

    // ****************************************************************
    // field positions
    // ****************************************************************
    localparam int capture_pin_select_bit = 0;
    localparam int compare_pin_select_bit = 1;
    localparam int compare_output_level_bit = 0;
    localparam int capture_edge_select_bit = 1;
    localparam int capture_flag_bit = 7;
    localparam int compare_flag_bit = 6;
    localparam int counter_wrap_flag_bit = 5;
    localparam logic [7:0] control_write_mask = 8'h03;
    localparam logic [7:0] pin_select_write_mask = 8'h03;
    localparam logic [7:0] flag_mask = 8'he0;

    // ****************************************************************
    // reset values and timing
    // ****************************************************************
    localparam logic [15:0] count_reset = 16'hfffc;
    localparam logic [7:0] pin_select_reset = 8'h00;
    localparam logic [7:0] control_reset = 8'h00;
    localparam logic [15:0] compare_reset = 16'hffff;
    localparam logic [1:0] prescale_last = 2'h3;

    localparam logic [1:0] resp_okay = 2'h0;
    localparam logic [1:0] resp_slverr = 2'h2;

endpackage

/* File: capcmp_edge_sync.sv */
// edge finder for the capture pin: two-flop synchroniser, then an
// edge detector on the second flop; assumes pin is asynchronous to aclk
`timescale 1ns/1ps
module capcmp_edge_sync
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic pin,
    output logic rise,
    output logic fall
);
    typedef struct packed {
        logic meta;
        logic sync;
        logic prev;
    } sync_state_t;

    sync_state_t state_r;
    sync_state_t state_nxt;

    always_comb
    begin
        state_nxt = state_r;
        state_nxt.meta = pin;
        state_nxt.sync = state_r.meta;
        state_nxt.prev = state_r.sync;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            state_r <= '0;
        end
        else
        begin
            state_r <= state_nxt;
        end
    end

    assign rise = state_r.sync && !state_r.prev;
    assign fall = !state_r.sync && state_r.prev;

    // an edge must match the pin level two samples back
    a_edge_source: assert property (@(posedge aclk) disable iff (!aresetn)
        (rise |-> $past(pin, 2)) and (fall |-> !$past(pin, 2)))
        else $error("edge does not match pin history");
endmodule // capcmp_edge_sync

/* File: capcmp_timer.sv */
// capture/compare timer with free-running counter and axi4-lite regs
// assumes one 200 mhz clock, synchronous active-low reset, raw pins
//
// Functional notes
// - read-only 16-bit counter steps once per four bus clocks.
// - selected capture pin edge copies count into capture register.
// - counter equal to compare value drives programmed level on pin.
// - capture and compare work only once pin select bits set.
// - compare select bit set makes port c line 1 the compare output.
// - capture select bit set makes port c line 0 the capture input.
// - high byte access suspends function until low byte accessed.
// - counter changes away from read sampling, reads see stable value.
// - reading the counter never changes its count.
// - reset presets counter to fffc, counting resumes from there.
// - edge select one picks rising, zero picks falling capture edges.
// - level control clocked to output register on next compare match.
// - wrap from ffff to 0000 sets counter wrap flag.
//
// The AXI4-Lite register port was left to the implementer.
`timescale 1ns/1ps
module capcmp_timer
    import capcmp_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [capcmp_pkg::addr_width-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [capcmp_pkg::addr_width-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic capture_input_pin,
    input wire logic gpio_c1_out,
    input wire logic gpio_c1_oe,
    output logic port_c1_out,
    output logic port_c1_oe,
    output logic compare_output_pin,
    output logic irq
);
    import capcmp_pkg::*;

    typedef struct packed {
        logic aw_have;
        logic [7:0] aw_idx;
        logic w_have;
        logic [7:0] w_data;
        logic w_lane0;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [7:0] rdata;
        logic [1:0] rresp;
        logic [1:0] prescale;
        logic tick_d;
        logic [15:0] count;
        logic [7:0] count_buf;
        logic count_lock;
        logic [15:0] capture;
        logic capture_inh;
        logic [15:0] compare;
        logic compare_inh;
        logic level;
        logic [7:0] pin_select;
        logic [7:0] control;
        logic [7:0] flags;
        logic [7:0] mask;
    } timer_state_t;

    timer_state_t st_r;
    timer_state_t st_nxt;
    logic cap_rise;
    logic cap_fall;
    logic tick;
    logic capture_evt;
    logic compare_evt;
    logic wrap_evt;
    logic wr_go;
    logic rd_go;
    logic [7:0] rd_idx;
    logic [7:0] rd_val;
    logic rd_ok;
    logic wr_ok;
    logic [7:0] set_bits;

    // ****************************************************************
    // capture pin edges
    // ****************************************************************
    capcmp_edge_sync edge_sync_i
    (
        .aclk(aclk),
        .aresetn(aresetn),
        .pin(capture_input_pin),
        .rise(cap_rise),
        .fall(cap_fall)
    );

    // ****************************************************************
    // timer events
    // ****************************************************************
    assign tick = (st_r.prescale == prescale_last);
    assign wrap_evt = tick && (st_r.count == 16'hffff);
    assign capture_evt = st_r.pin_select[capture_pin_select_bit]
        && !st_r.capture_inh
        && (st_r.control[capture_edge_select_bit] ? cap_rise
            : cap_fall);
    assign compare_evt = st_r.pin_select[compare_pin_select_bit]
        && !st_r.compare_inh && st_r.tick_d
        && (st_r.count == st_r.compare);

    assign set_bits = {capture_evt, compare_evt, wrap_evt, 5'h00};

    // ****************************************************************
    // bus handshakes and decode
    // ****************************************************************
    assign s_axi_awready = !st_r.aw_have && !st_r.bvalid;
    assign s_axi_wready = !st_r.w_have && !st_r.bvalid;
    assign s_axi_arready = !st_r.rvalid;
    assign s_axi_bvalid = st_r.bvalid;
    assign s_axi_bresp = st_r.bresp;
    assign s_axi_rvalid = st_r.rvalid;
    assign s_axi_rresp = st_r.rresp;
    assign s_axi_rdata = {24'h000000, st_r.rdata};
    assign wr_go = st_r.aw_have && st_r.w_have && !st_r.bvalid;
    assign rd_go = s_axi_arvalid && s_axi_arready;
    assign rd_idx = {2'b00, s_axi_araddr[7:2]};
    assign wr_ok = (st_r.aw_idx == idx_pin_select)
        || (st_r.aw_idx == idx_control)
        || (st_r.aw_idx == idx_compare_hi)
        || (st_r.aw_idx == idx_compare_lo)
        || (st_r.aw_idx == idx_irq_status)
        || (st_r.aw_idx == idx_irq_mask);

    always_comb
    begin
        rd_ok = 1'b1;
        rd_val = 8'h00;
        unique case (rd_idx)
            idx_pin_select: rd_val = st_r.pin_select;
            idx_control: rd_val = st_r.control;
            idx_status: rd_val = st_r.flags;
            idx_capture_hi: rd_val = st_r.capture[15:8];
            idx_capture_lo: rd_val = st_r.capture[7:0];
            idx_compare_hi: rd_val = st_r.compare[15:8];
            idx_compare_lo: rd_val = st_r.compare[7:0];
            idx_count_hi, idx_alt_count_hi: rd_val = st_r.count[15:8];
            idx_count_lo, idx_alt_count_lo:
                rd_val = st_r.count_lock ? st_r.count_buf
                    : st_r.count[7:0];
            idx_irq_status: rd_val = st_r.flags;
            idx_irq_mask: rd_val = st_r.mask;
            default: rd_ok = 1'b0;
        endcase
    end

    // ****************************************************************
    // next state
    // ****************************************************************
    always_comb
    begin
        st_nxt = st_r;
        // prescaler and counter: only the prescaler tick moves the
        // count, so a read never disturbs it
        st_nxt.prescale = st_r.prescale + 2'h1;
        st_nxt.tick_d = tick;
        if (tick)
        begin
            st_nxt.count = st_r.count + 16'h0001;
        end
        if (capture_evt)
        begin
            st_nxt.capture = st_r.count;
        end
        if (compare_evt)
        begin
            st_nxt.level = st_r.control[compare_output_level_bit];
        end
        // write channel
        if (s_axi_awvalid && s_axi_awready)
        begin
            st_nxt.aw_have = 1'b1;
            st_nxt.aw_idx = {2'b00, s_axi_awaddr[7:2]};
        end
        if (s_axi_wvalid && s_axi_wready)
        begin
            st_nxt.w_have = 1'b1;
            st_nxt.w_data = s_axi_wdata[7:0];
            st_nxt.w_lane0 = s_axi_wstrb[0];
        end
        if (wr_go)
        begin
            st_nxt.aw_have = 1'b0;
            st_nxt.w_have = 1'b0;
            st_nxt.bvalid = 1'b1;
            st_nxt.bresp = wr_ok ? resp_okay : resp_slverr;
            if (st_r.w_lane0)
            begin
                unique case (st_r.aw_idx)
                    idx_pin_select: st_nxt.pin_select =
                        st_r.w_data & pin_select_write_mask;
                    idx_control: st_nxt.control =
                        st_r.w_data & control_write_mask;
                    idx_compare_hi:
                    begin
                        st_nxt.compare[15:8] = st_r.w_data;
                        st_nxt.compare_inh = 1'b1;
                    end
                    idx_compare_lo:
                    begin
                        st_nxt.compare[7:0] = st_r.w_data;
                        st_nxt.compare_inh = 1'b0;
                    end
                    idx_irq_status: st_nxt.flags =
                        st_r.flags & ~(st_r.w_data & flag_mask);
                    idx_irq_mask: st_nxt.mask = st_r.w_data & flag_mask;
                    default: st_nxt.bresp = resp_slverr;
                endcase
            end
        end
        if (st_r.bvalid && s_axi_bready)
        begin
            st_nxt.bvalid = 1'b0;
        end
        // read channel and its side effects
        if (rd_go)
        begin
            st_nxt.rvalid = 1'b1;
            st_nxt.rdata = rd_val;
            st_nxt.rresp = rd_ok ? resp_okay : resp_slverr;
            if ((rd_idx == idx_count_hi || rd_idx == idx_alt_count_hi)
                && !st_r.count_lock)
            begin
                st_nxt.count_lock = 1'b1;
                st_nxt.count_buf = st_r.count[7:0];
            end
            if (rd_idx == idx_count_lo || rd_idx == idx_alt_count_lo)
            begin
                st_nxt.count_lock = 1'b0;
            end
            if (rd_idx == idx_capture_hi)
            begin
                st_nxt.capture_inh = 1'b1;
            end
            if (rd_idx == idx_capture_lo)
            begin
                st_nxt.capture_inh = 1'b0;
            end
        end
        if (st_r.rvalid && s_axi_rready)
        begin
            st_nxt.rvalid = 1'b0;
        end
        // hardware set wins over a same-cycle software clear
        st_nxt.flags = st_nxt.flags | set_bits;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            st_r <= '0;
            st_r.count <= count_reset;
            st_r.compare <= compare_reset;
            st_r.pin_select <= pin_select_reset;
            st_r.control <= control_reset;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    // ****************************************************************
    // pins and interrupt
    // ****************************************************************
    assign compare_output_pin = st_r.level;
    assign port_c1_out = st_r.pin_select[compare_pin_select_bit]
        ? st_r.level : gpio_c1_out;
    assign port_c1_oe = st_r.pin_select[compare_pin_select_bit]
        || gpio_c1_oe;
    assign irq = |(st_r.flags & st_r.mask);

    // ****************************************************************
    // assertions
    // ****************************************************************
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    a_count_step: assert property (
        tick |=> st_r.count == $past(st_r.count) + 16'h0001)
        else $error("counter did not step on tick");
    a_count_still: assert property (
        !tick |=> $stable(st_r.count))
        else $error("counter moved without a tick");
    a_tick_spacing: assert property (
        tick |=> !tick ##1 !tick ##1 !tick ##1 tick)
        else $error("prescaler is not divide by four");
    a_reset_preset: assert property (
        $rose(aresetn) |-> st_r.count == count_reset)
        else $error("counter not preset at reset");
    a_wrap_flag: assert property (
        wrap_evt |=> st_r.flags[counter_wrap_flag_bit]
            && st_r.count == 16'h0000)
        else $error("wrap flag not set on wrap");
    a_capture_copy: assert property (
        capture_evt |=> st_r.capture == $past(st_r.count)
            && st_r.flags[capture_flag_bit])
        else $error("capture did not latch count");
    a_capture_gate: assert property (
        !st_r.pin_select[capture_pin_select_bit] |=>
            $stable(st_r.capture))
        else $error("capture while pin not selected");
    a_compare_level: assert property (
        compare_evt |=> compare_output_pin ==
            $past(st_r.control[compare_output_level_bit]))
        else $error("compare level not applied");
    a_compare_hold: assert property (
        st_r.compare_inh |=> $stable(compare_output_pin)
            && !$rose(st_r.flags[compare_flag_bit]))
        else $error("compare ran while suspended");
    a_pin_mux: assert property (
        st_r.pin_select[compare_pin_select_bit] |->
            port_c1_oe && port_c1_out == compare_output_pin)
        else $error("port line not given to compare");
    a_read_answer: assert property (
        rd_go |=> s_axi_rvalid)
        else $error("read answer late");

    c_wrap: cover property (wrap_evt);
    c_capture: cover property (capture_evt);
    c_compare: cover property (compare_evt);
    c_locked_read: cover property (rd_go && st_r.count_lock);
endmodule // capcmp_timer

/* File: pins_model.sv */
// far-side model of the capture/compare timer pins: the capture pin
// and the ordinary port logic of line 1; assumes one clock, aclk
`timescale 1ns/1ps
module pins_model
(
    input wire logic aclk,
    output logic cap_pin,
    output logic gpio_out,
    output logic gpio_oe
);
    initial
    begin
        cap_pin = 1'b0;
        gpio_out = 1'b0;
        gpio_oe = 1'b1;
    end

    // port logic toggles every cycle so a stuck pass-through shows;
    // the enable trails it by one cycle so a stuck enable shows too
    always @(posedge aclk)
    begin
        gpio_out <= ~gpio_out;
        gpio_oe <= gpio_out;
    end

    // level changes land just after an edge, held until the next call
    task automatic set_cap(input logic v);
        @(posedge aclk);
        cap_pin <= v;
    endtask
endmodule // pins_model

/* File: testbench.sv */
// self-checking bench for capcmp_timer: axi4-lite master tasks and
// register-level tests; assumes capcmp_pkg and pins_model are compiled
`timescale 1ns/1ps
module testbench;
    import capcmp_pkg::*;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'h0;
    logic awready, wready, bvalid, arready, rvalid, irq;
    logic [1:0] bresp, rresp, resp;
    logic [31:0] rdata, rdat;
    logic cap_pin, gpio_out, gpio_oe, c1_out, c1_oe, cmp_pin;
    logic [15:0] cur, cap, v;
    logic [7:0] l0;
    int error_cnt = 0, comparisons = 0, cyc = 0, t0;

    always #2.5 aclk = ~aclk;

    capcmp_timer dut (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .capture_input_pin(cap_pin),
        .gpio_c1_out(gpio_out), .gpio_c1_oe(gpio_oe),
        .port_c1_out(c1_out), .port_c1_oe(c1_oe),
        .compare_output_pin(cmp_pin), .irq(irq));

    pins_model pins (.aclk(aclk), .cap_pin(cap_pin),
        .gpio_out(gpio_out), .gpio_oe(gpio_oe));

    // ****************************************************************
    // bus tasks and comparison
    // ****************************************************************
    task automatic close_out();
        if (error_cnt == 0 && comparisons > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task automatic check(input string nm, input logic [31:0] seen,
                         input logic [31:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("BAD %s exp %h seen %h", nm, exp, seen);
        end
    endtask

    // address and data offered together, each released when taken
    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        bit ah, wh, bh;
        @(posedge aclk);
        awaddr <= {idx[5:0], 2'b00};
        awvalid <= 1'b1;
        wdata <= {24'h0, d};
        wstrb <= 4'h1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do
        begin
            @(negedge aclk);
            ah = awvalid && awready;
            wh = wvalid && wready;
            bh = bvalid;
            resp = bresp;
            @(posedge aclk);
            awvalid <= awvalid && !ah;
            wvalid <= wvalid && !wh;
        end
        while (!bh);
        bready <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] idx);
        bit ah, rh;
        @(posedge aclk);
        araddr <= {idx[5:0], 2'b00};
        arvalid <= 1'b1;
        rready <= 1'b1;
        do
        begin
            @(negedge aclk);
            ah = arvalid && arready;
            rh = rvalid;
            rdat = rdata;
            resp = rresp;
            @(posedge aclk);
            arvalid <= arvalid && !ah;
        end
        while (!rh);
        rready <= 1'b0;
    endtask

    // high byte first, then always the low byte to end the pair
    task automatic rd16(input logic [7:0] hi, output logic [15:0] r);
        rd(hi);
        r[15:8] = rdat[7:0];
        rd(hi + 8'h01);
        r[7:0] = rdat[7:0];
    endtask

    always @(posedge aclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            error_cnt++;
            close_out();
        end
    end

    // ****************************************************************
    // tests
    // ****************************************************************
    initial
    begin
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        check("irq_rst", 32'(irq), 32'h0);
        check("cmp_rst", 32'(cmp_pin), 32'h0);
        rd16(idx_count_hi, v);
        check("cnt_rst", 32'(v >= 16'hfffc), 32'h1);
        rd(idx_pin_select);
        check("sel_rst", rdat, 32'h0);
        repeat (20) @(posedge aclk);
        rd(idx_irq_status);
        check("wrap_irq", rdat & 32'h20, 32'h20);
        rd(idx_status);
        check("wrap_sts", rdat & 32'h20, 32'h20);
        check("irq_mask0", 32'(irq), 32'h0);
        wr(idx_irq_mask, 8'h20);
        check("ok_bresp", 32'(resp), 32'(resp_okay));
        repeat (2) @(posedge aclk);
        check("irq_on", 32'(irq), 32'h1);
        wr(idx_irq_status, 8'h20);
        repeat (2) @(posedge aclk);
        check("irq_off", 32'(irq), 32'h0);
        rd(idx_irq_mask);
        check("mask_rb", rdat, 32'h20);
        check("ok_rresp", 32'(resp), 32'(resp_okay));
        wr(idx_irq_mask, 8'h00);
        @(negedge aclk);
        check("c1_pass", 32'(c1_out), 32'(gpio_out));
        check("c1_oe", 32'(c1_oe), 32'(gpio_oe));
        rd(8'h0f);
        check("unm_rresp", 32'(resp), 32'(resp_slverr));
        check("unm_rdata", rdat, 32'h0);
        wr(8'h0f, 8'h55);
        check("unm_bresp", 32'(resp), 32'(resp_slverr));
        // live low byte twice; steps must match elapsed cycles / 4
        t0 = cyc;
        rd(idx_count_lo);
        l0 = rdat[7:0];
        repeat (100) @(posedge aclk);
        t0 = (cyc - t0) / 4;
        rd(idx_alt_count_lo);
        l0 = rdat[7:0] - l0;
        check("rate", 32'(l0 >= t0 && l0 <= t0 + 1), 32'h1);
        // pin not yet handed over: no capture
        pins.set_cap(1'b1);
        pins.set_cap(1'b0);
        repeat (10) @(posedge aclk);
        rd(idx_irq_status);
        check("cap_off", rdat & 32'h80, 32'h0);
        wr(idx_pin_select, 8'hff);
        rd(idx_pin_select);
        check("sel_rb", rdat, 32'h3);
        for (int e = 0; e < 2; e++)
        begin
            // park the pin so that the wrong edge comes next
            pins.set_cap(e[0]);
            repeat (5) @(posedge aclk);
            wr(idx_control, {6'h0, e[0], 1'b0});
            wr(idx_irq_status, 8'he0);
            pins.set_cap(!e[0]);
            repeat (10) @(posedge aclk);
            rd(idx_irq_status);
            check("cap_wrong", rdat & 32'h80, 32'h0);
            rd16(idx_count_hi, cur);
            pins.set_cap(e[0]);
            repeat (10) @(posedge aclk);
            rd(idx_irq_status);
            check("cap_flag", rdat & 32'h80, 32'h80);
            rd16(idx_capture_hi, cap);
            check("cap_val", 32'(16'(cap - cur) <= 16'd4), 32'h1);
        end
        rd(idx_capture_hi);
        pins.set_cap(1'b0);
        pins.set_cap(1'b1);
        repeat (10) @(posedge aclk);
        rd(idx_capture_lo);
        check("cap_hold", rdat, {24'h0, cap[7:0]});
        wr(idx_control, 8'h03);
        rd16(idx_count_hi, cur);
        cur = cur + 16'd30;
        wr(idx_compare_hi, cur[15:8]);
        wr(idx_compare_lo, cur[7:0]);
        repeat (200) @(posedge aclk);
        check("cmp_high", 32'(cmp_pin), 32'h1);
        @(negedge aclk);
        check("c1_cmp", 32'(c1_out), 32'h1);
        check("c1_cmp_oe", 32'(c1_oe), 32'h1);
        rd(idx_irq_status);
        check("cmp_flag", rdat & 32'h40, 32'h40);
        wr(idx_control, 8'h02);
        rd16(idx_count_hi, cur);
        cur = cur + 16'd30;
        wr(idx_compare_hi, cur[15:8]);
        repeat (200) @(posedge aclk);
        check("cmp_susp", 32'(cmp_pin), 32'h1);
        rd16(idx_count_hi, cur);
        cur = cur + 16'd30;
        wr(idx_compare_hi, cur[15:8]);
        wr(idx_compare_lo, cur[7:0]);
        repeat (200) @(posedge aclk);
        check("cmp_low", 32'(cmp_pin), 32'h0);
        close_out();
    end
endmodule // testbench
